/* File: rtl/aftl_host.sv */
// Purpose: host end, feeds a filter table load over the setup register
// Assumes: user words arrive with valid/ready, one per accepted cycle
// Notes:   mode and byte order are caught at start and held
`include "aftl_regs.svh"

module aftl_host (
  input  wire logic        clock,
  input  wire logic        reset_n,
  aftl_if.host             link,
  input  wire logic        load_start,
  input  wire logic        load_hash_mode,
  input  wire logic        load_little_endian,
  input  wire logic [31:0] word_data,
  input  wire logic        word_valid,
  output logic             word_ready,
  output logic             load_busy,
  output logic             load_done
);

  aftl_pkg::aftl_host_state_t state_r;
  aftl_pkg::aftl_host_state_t state_nxt;
  logic [1:0]                 timer_r;
  logic [1:0]                 timer_nxt;
  logic [5:0]                 count_r;
  logic [5:0]                 count_nxt;
  logic [5:0]                 total;
  logic                       wake_r;
  logic                       wake_nxt;
  logic                       strobe_r;
  logic                       strobe_nxt;
  logic [31:0]                word_r;
  logic [31:0]                word_nxt;
  logic                       hash_r;
  logic                       hash_nxt;
  logic                       little_r;
  logic                       little_nxt;
  logic                       done_r;
  logic                       done_nxt;

  // hash load carries the table plus one address, perfect load 16 pairs
  assign total      = hash_r ? 6'(`AFTL_HASH_WORDS + `AFTL_PERF_ADDR_WORDS)
                             : `AFTL_PERF_WORDS;
  assign word_ready = (state_r == aftl_pkg::HOST_SEND);
  assign load_busy  = (state_r != aftl_pkg::HOST_IDLE);
  assign load_done  = done_r;

  always_comb begin
    state_nxt  = state_r;
    timer_nxt  = timer_r;
    count_nxt  = count_r;
    wake_nxt   = wake_r;
    strobe_nxt = 1'b0;
    word_nxt   = word_r;
    hash_nxt   = hash_r;
    little_nxt = little_r;
    done_nxt   = 1'b0;
    case (state_r)
      aftl_pkg::HOST_IDLE: begin
        if (load_start) begin
          hash_nxt   = load_hash_mode;
          little_nxt = load_little_endian;
          wake_nxt   = 1'b1;
          timer_nxt  = 2'h0;
          count_nxt  = 6'h00;
          state_nxt  = aftl_pkg::HOST_LEAD;
        end
      end
      aftl_pkg::HOST_LEAD: begin
        timer_nxt = 2'(timer_r + 2'h1);
        if (timer_nxt == `AFTL_WAKE_LEAD) begin
          state_nxt = aftl_pkg::HOST_SEND;
        end
      end
      aftl_pkg::HOST_SEND: begin
        if (word_valid) begin
          strobe_nxt = 1'b1;
          word_nxt   = word_data;
          count_nxt  = 6'(count_r + 6'h01);
          if (count_nxt == total) begin
            timer_nxt = 2'h0;
            state_nxt = aftl_pkg::HOST_TRAIL;
          end
        end
      end
      aftl_pkg::HOST_TRAIL: begin
        timer_nxt = 2'(timer_r + 2'h1);
        if (timer_nxt == `AFTL_WAKE_TRAIL) begin
          wake_nxt  = 1'b0;
          done_nxt  = 1'b1;
          state_nxt = aftl_pkg::HOST_IDLE;
        end
      end
      default: state_nxt = aftl_pkg::HOST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r  <= aftl_pkg::HOST_IDLE;
      timer_r  <= 2'h0;
      count_r  <= 6'h00;
      wake_r   <= 1'b0;
      strobe_r <= 1'b0;
      word_r   <= 32'h0000_0000;
      hash_r   <= 1'b0;
      little_r <= 1'b0;
      done_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      timer_r  <= timer_nxt;
      count_r  <= count_nxt;
      wake_r   <= wake_nxt;
      strobe_r <= strobe_nxt;
      word_r   <= word_nxt;
      hash_r   <= hash_nxt;
      little_r <= little_nxt;
      done_r   <= done_nxt;
    end
  end

  assign link.setup_write_strobe   = strobe_r;
  assign link.setup_word_in        = word_r;
  assign link.loader_wakeup        = wake_r;
  assign link.hash_mode_select     = hash_r;
  assign link.little_endian_select = little_r;

endmodule : aftl_host

/* File: rtl/aftl_if.sv */
// Purpose: link between host register side and table loader
// Assumes: all signals on the free host clock
// Notes:   no clocking block, the bench joins the ends
interface aftl_if;
  logic        setup_write_strobe;
  logic [31:0] setup_word_in;
  logic        loader_wakeup;
  logic        hash_mode_select;
  logic        little_endian_select;
  logic        gated_clock_request;

  modport loader (
    input  setup_write_strobe,
    input  setup_word_in,
    input  loader_wakeup,
    input  hash_mode_select,
    input  little_endian_select,
    output gated_clock_request
  );

  modport host (
    output setup_write_strobe,
    output setup_word_in,
    output loader_wakeup,
    output hash_mode_select,
    output little_endian_select,
    input  gated_clock_request
  );
endinterface : aftl_if

/* File: rtl/aftl_loader.sv */
// Purpose: loads hash table and exact-match addresses from setup words
// Assumes: gated_host_clock is clock gated by gated_clock_request
// Notes:   sequencer and table outputs run on the gated clock
//
// Notes on behaviour
// - host loads tables before reception starts
// - hash mode: sixteen words carry hash table
// - then two words carry one exact address
// - perfect mode: thirty-two words, sixteen addresses
// - word layout follows byte order and mode
// - wake-up leads first strobe by three cycles
// - take 32-bit word with write strobe
// - drive 2-bit enable, 48-bit data, 4-bit address
// - hash select picks hash or sixteen addresses
// - idle goes to first write on strobe
// - first write, address mode, strobe: back idle
// - first write, hash, address F: second write
// - second, third advance on strobe; fourth idles
// - async active-low reset returns sequencer idle
// - clock enable on free clock, outputs gated
// - low little-endian select swaps word bytes
// - high little-endian select passes word unchanged
`include "aftl_regs.svh"

module aftl_loader #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 48
) (
  input  wire logic              clock,
  input  wire logic              gated_host_clock,
  input  wire logic              reset_n,
  aftl_if.loader                 link,
  output logic [1:0]             table_write_enable,
  output logic [DATA_W-1:0]      table_write_data,
  output logic [ADDR_W-1:0]      table_write_address
);

  aftl_pkg::aftl_load_state_t state_r;
  aftl_pkg::aftl_load_state_t state_nxt;
  logic [ADDR_W-1:0]          addr_r;
  logic [ADDR_W-1:0]          addr_nxt;
  logic [31:0]                low_r;
  logic [31:0]                low_nxt;
  logic [1:0]                 we_r;
  logic [1:0]                 we_nxt;
  logic [DATA_W-1:0]          data_r;
  logic [DATA_W-1:0]          data_nxt;
  logic [ADDR_W-1:0]          waddr_r;
  logic [ADDR_W-1:0]          waddr_nxt;
  logic                       clk_req_r;
  logic                       clk_req_nxt;
  logic [31:0]                word_le;
  logic                       strobe;
  logic                       hash;

  // byte order translator, purely combinational
  function automatic logic [31:0] to_little(
    input logic [31:0] word,
    input logic        little
  );
    logic [31:0] swapped;
    swapped = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      swapped[8*b +: 8] = word[8*(3-b) +: 8];
    end
    return little ? word : swapped;
  endfunction : to_little

  // hash word fills the low part; upper bits of a hash entry stay zero
  function automatic logic [DATA_W-1:0] hash_entry(
    input logic [31:0] word
  );
    logic [DATA_W-1:0] e;
    e = '0;
    e[`AFTL_LOW_MSB:`AFTL_LOW_LSB] = word;
    return e;
  endfunction : hash_entry

  // first word gives address bits 31..0, second word bits 47..32
  function automatic logic [DATA_W-1:0] addr_entry(
    input logic [31:0] low,
    input logic [31:0] high
  );
    logic [DATA_W-1:0] e;
    e = '0;
    e[`AFTL_LOW_MSB:`AFTL_LOW_LSB]   = low;
    e[`AFTL_HIGH_MSB:`AFTL_HIGH_LSB] = high[15:0];
    return e;
  endfunction : addr_entry

  // translation sits ahead of the sequencer so both modes see one byte order
  assign word_le = to_little(link.setup_word_in, link.little_endian_select);
  assign strobe  = link.setup_write_strobe;
  assign hash    = link.hash_mode_select;

  always_comb begin
    state_nxt = state_r;
    addr_nxt  = addr_r;
    low_nxt   = low_r;
    we_nxt    = `AFTL_WE_NONE;
    data_nxt  = data_r;
    waddr_nxt = waddr_r;
    case (state_r)
      aftl_pkg::LOAD_IDLE: begin
        if (strobe) begin
          state_nxt = aftl_pkg::LOAD_WRITE_1;
          if (hash) begin
            we_nxt    = `AFTL_WE_HASH;
            data_nxt  = hash_entry(word_le);
            waddr_nxt = addr_r;
          end else begin
            // first word of a pair waits here; nothing is written yet
            low_nxt = word_le;
          end
        end
      end
      aftl_pkg::LOAD_WRITE_1: begin
        if (strobe && !hash) begin
          state_nxt = aftl_pkg::LOAD_IDLE;
          we_nxt    = `AFTL_WE_ADDR;
          data_nxt  = addr_entry(low_r, word_le);
          waddr_nxt = addr_r;
        end else if (strobe && hash) begin
          we_nxt    = `AFTL_WE_HASH;
          data_nxt  = hash_entry(word_le);
          waddr_nxt = addr_r;
          // the counter names the entry being written, so F means the 16th word
          if (addr_r == ADDR_W'(`AFTL_LAST_ADDR)) begin
            state_nxt = aftl_pkg::LOAD_WRITE_2;
          end
        end
      end
      aftl_pkg::LOAD_WRITE_2: begin
        if (strobe) begin
          low_nxt   = word_le;
          state_nxt = aftl_pkg::LOAD_WRITE_3;
        end
      end
      aftl_pkg::LOAD_WRITE_3: begin
        if (strobe) begin
          we_nxt    = `AFTL_WE_ADDR;
          data_nxt  = addr_entry(low_r, word_le);
          waddr_nxt = addr_r;
          state_nxt = aftl_pkg::LOAD_WRITE_4;
        end
      end
      aftl_pkg::LOAD_WRITE_4: begin
        // a strobe landing here is lost; the host leaves idle cycles after
        // the last word, so a well-behaved host never hits this
        state_nxt = aftl_pkg::LOAD_IDLE;
      end
      default: begin
        state_nxt = aftl_pkg::LOAD_IDLE;
      end
    endcase
    // one step per table entry written; wraps to zero after entry F
    // perfect mode passes idle between pairs, so idle alone cannot clear it
    if (we_nxt != `AFTL_WE_NONE) begin
      addr_nxt = ADDR_W'(addr_r + 1'b1);
    end
    if (state_r == aftl_pkg::LOAD_WRITE_4) begin
      addr_nxt = '0;
    end
  end

  // table side, only ticks while the gate is open
  always_ff @(posedge gated_host_clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= aftl_pkg::LOAD_IDLE;
      addr_r  <= '0;
      low_r   <= 32'h0000_0000;
      we_r    <= `AFTL_WE_NONE;
      data_r  <= '0;
      waddr_r <= '0;
    end else begin
      state_r <= state_nxt;
      addr_r  <= addr_nxt;
      low_r   <= low_nxt;
      we_r    <= we_nxt;
      data_r  <= data_nxt;
      waddr_r <= waddr_nxt;
    end
  end

  // gate request: wake-up opens it, a sequence in flight keeps it open,
  // so a late wake-up drop cannot freeze the sequencer mid-entry
  always_comb begin
    clk_req_nxt = link.loader_wakeup
                | (state_r != aftl_pkg::LOAD_IDLE)
                | (we_r != `AFTL_WE_NONE);
  end

  // free clock, so the gate can open before the first gated edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_req_r <= 1'b0;
    end else begin
      clk_req_r <= clk_req_nxt;
    end
  end

  assign link.gated_clock_request = clk_req_r;
  assign table_write_enable       = we_r;
  assign table_write_data         = data_r;
  assign table_write_address      = waddr_r;

endmodule : aftl_loader

/* File: rtl/aftl_pkg.sv */
// Purpose: types of the address filter table loader
// Assumes: nothing
// Notes:   constants live in aftl_regs.svh
package aftl_pkg;

  // sequencer of the table loader
  typedef enum logic [2:0] {
    LOAD_IDLE,
    LOAD_WRITE_1,
    LOAD_WRITE_2,
    LOAD_WRITE_3,
    LOAD_WRITE_4
  } aftl_load_state_t;

  // sequencer of the host side
  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_LEAD,
    HOST_SEND,
    HOST_TRAIL
  } aftl_host_state_t;

endpackage : aftl_pkg

/* File: rtl/aftl_regs.svh */
// Purpose: shared constants of the address filter table loader
// Assumes: included by bare name from both ends and the verification files
// Notes:   definitions only
`ifndef AFTL_REGS_SVH
`define AFTL_REGS_SVH

// setup words in each load sequence
`define AFTL_HASH_WORDS      6'h10
`define AFTL_PERF_ADDR_WORDS 6'h02
`define AFTL_PERF_WORDS      6'h20

// last table address of the hash store
`define AFTL_LAST_ADDR       4'hF

// table write enable codes
`define AFTL_WE_NONE         2'h0
`define AFTL_WE_HASH         2'h1
`define AFTL_WE_ADDR         2'h2

// field positions inside a table entry
`define AFTL_LOW_LSB         0
`define AFTL_LOW_MSB         31
`define AFTL_HIGH_LSB        32
`define AFTL_HIGH_MSB        47

// wake-up lead and trail in host clock cycles
`define AFTL_WAKE_LEAD       2'h2
`define AFTL_WAKE_TRAIL      2'h2

`endif

/* File: verification/aftl_properties.sv */
// Purpose: link checks between host end and table loader
// Assumes: all link signals on the free host clock
// Notes:   strobe counter lets one check see a whole sequence
`include "aftl_regs.svh"

module aftl_properties (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        setup_write_strobe,
  input wire logic [31:0] setup_word_in,
  input wire logic        loader_wakeup,
  input wire logic        hash_mode_select,
  input wire logic        little_endian_select,
  input wire logic        gated_clock_request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;

  // cleared outside wake-up so each sequence counts from zero
  always_comb begin
    cnt_nxt = cnt_r;
    if (!loader_wakeup) cnt_nxt = 6'h00;
    else if (setup_write_strobe) cnt_nxt = cnt_r + 6'h01;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) cnt_r <= 6'h00;
    else cnt_r <= cnt_nxt;
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_wake_lead: assert property (setup_write_strobe |-> $past(loader_wakeup, 2))
    else $error("strobe without wake-up lead");
  chk_wake_trail: assert property (setup_write_strobe |-> loader_wakeup ##1 loader_wakeup)
    else $error("wake-up dropped too early");
  chk_quiet_idle: assert property (!loader_wakeup |-> !setup_write_strobe)
    else $error("strobe outside wake-up");
  chk_mode_stable: assert property (loader_wakeup && $past(loader_wakeup) |->
    $stable(hash_mode_select) && $stable(little_endian_select))
    else $error("mode changed in a sequence");
  chk_word_stable: assert property (loader_wakeup && $past(loader_wakeup) && !setup_write_strobe |->
    $stable(setup_word_in))
    else $error("setup word changed without strobe");
  chk_word_count: assert property ($fell(loader_wakeup) |->
    cnt_r == ($past(hash_mode_select) ? `AFTL_HASH_WORDS + `AFTL_PERF_ADDR_WORDS : `AFTL_PERF_WORDS))
    else $error("wrong setup word count");
  chk_clock_request: assert property (loader_wakeup |=> gated_clock_request)
    else $error("gate closed during wake-up");
  chk_req_drop: assert property ($fell(loader_wakeup) |-> ##[1:4] !gated_clock_request)
    else $error("gate left open after load");
  chk_req_cause: assert property ($rose(gated_clock_request) |-> $past(loader_wakeup))
    else $error("gate opened without wake-up");

  cover property ($fell(loader_wakeup) && hash_mode_select);
  cover property ($fell(loader_wakeup) && !hash_mode_select);
  cover property (setup_write_strobe [*3]);
endmodule : aftl_properties

/* File: verification/aftl_tb_top.sv */
// Purpose: bench joining host end and loader over the link
// Assumes: gate latch for the loader clock is built here
// Notes:   random words from a fixed seed, plus reset and busy corners
`include "aftl_regs.svh"

module aftl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, reset_n, g_clk, gate_l, load_start, hm, le, word_valid;
  logic        word_ready, load_busy, load_done;
  logic [31:0] word_data;
  logic [31:0] w [32];
  logic [1:0]  twe;
  logic [47:0] twd;
  logic [3:0]  twa;
  logic [53:0] exp_q [$];
  int          errors, n_tests, seed, i;

  aftl_if link ();
  aftl_host aftl_host_inst (.clock(clock), .reset_n(reset_n), .link(link), .load_start(load_start),
    .load_hash_mode(hm), .load_little_endian(le), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .load_busy(load_busy), .load_done(load_done));
  aftl_loader aftl_loader_inst (.clock(clock), .gated_host_clock(g_clk), .reset_n(reset_n), .link(link),
    .table_write_enable(twe), .table_write_data(twd), .table_write_address(twa));
  aftl_properties aftl_properties_inst (.clock(clock), .reset_n(reset_n),
    .setup_write_strobe(link.setup_write_strobe), .setup_word_in(link.setup_word_in),
    .loader_wakeup(link.loader_wakeup), .hash_mode_select(link.hash_mode_select),
    .little_endian_select(link.little_endian_select), .gated_clock_request(link.gated_clock_request));

  // latch while clock is low so the gated clock never glitches
  always_latch begin
    if (!clock) gate_l <= link.gated_clock_request;
  end
  assign g_clk = clock & gate_l;

  function automatic logic [31:0] sw(input logic [31:0] x, input logic l);
    return l ? x : {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction : sw

  function automatic logic [47:0] ent(input logic [31:0] lo, input logic [31:0] hi, input logic l);
    logic [31:0] b;
    b = sw(hi, l);
    return {b[15:0], sw(lo, l)};
  endfunction : ent

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] expv);
    n_tests++;
    if (seen !== expv) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", name, expv, seen);
    end
  endtask : chk

  task automatic test_done();
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // negedge sampling sees the gated flops settled
  always @(negedge clock) begin
    if (reset_n && twe !== `AFTL_WE_NONE) begin
      chk("table write", {twe, twa, twd}, exp_q.size() ? exp_q.pop_front() : 54'h0);
    end
  end

  task automatic do_load(input logic h, input logic l, input logic gap, input int abort);
    int n, k, t, g;
    n = h ? 18 : 32;
    for (k = 0; k < 32; k++) w[k] = $random(seed);
    for (k = 0; k < 16; k++) begin
      if (h) exp_q.push_back({`AFTL_WE_HASH, 4'(k), ent(w[k], 32'h0, l)});
      else exp_q.push_back({`AFTL_WE_ADDR, 4'(k), ent(w[2*k], w[2*k+1], l)});
    end
    if (h) exp_q.push_back({`AFTL_WE_ADDR, 4'h0, ent(w[16], w[17], l)});
    @(posedge clock);
    load_start <= 1'b1;
    hm <= h;
    le <= l;
    for (k = 0; k < n; k++) begin
      if (k == abort) begin
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        chk("reset out", {twe, twa, twd, load_busy, link.gated_clock_request}, 64'h0);
        exp_q.delete();
        word_valid <= 1'b0;
        reset_n <= 1'b1;
        return;
      end
      word_data <= w[k];
      word_valid <= 1'b1;
      t = 0;
      do begin
        @(posedge clock);
        load_start <= (gap && k == 5 && t == 0);
        hm <= (gap && k == 5) ? !h : h;
        t++;
      end while (word_ready !== 1'b1 && t < 20);
      g = gap ? {$random(seed)} % 3 : 0;
      if (g > 0) begin
        word_valid <= 1'b0;
        word_data <= ~w[k];
        repeat (g) @(posedge clock);
      end
    end
    word_valid <= 1'b0;
    t = 0;
    while (load_done !== 1'b1 && t < 10) begin
      @(posedge clock);
      t++;
    end
    chk("done seen", t < 10, 64'h1);
    repeat (6) @(posedge clock);
    chk("left writes", exp_q.size(), 64'h0);
    chk("busy after", load_busy, 64'h0);
  endtask : do_load

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    test_done();
  end

  initial begin
    reset_n = 1'b0;
    load_start = 1'b0;
    hm = 1'b0;
    le = 1'b0;
    word_valid = 1'b0;
    word_data = 32'h0;
    errors = 0;
    n_tests = 0;
    seed = 5710;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    do_load(1'b1, 1'b0, 1'b0, 99);
    do_load(1'b0, 1'b1, 1'b0, 99);
    do_load(1'b1, 1'b1, 1'b1, 7); // reset mid-sequence
    do_load(1'b0, 1'b0, 1'b1, 99); // address restart and start while busy
    for (i = 0; i < 8; i++) do_load(1'($random(seed)), 1'($random(seed)), 1'b1, 99);
    test_done();
  end
endmodule : aftl_tb_top
